// ### design/port0_strap_defaults.sv
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/1ps
`include "strap_params.svh"

module port0_strap_defaults
    import port0_strap_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire reg_req_t regReq,
    output logic [31:0] rdata_q,
    input wire ee_load_t eeLoad,
    input wire logic [1:0] port0Mode,
    input wire logic port0_dup_indicator_pin,
    output logic fullDuplex_q,
    output logic port0_backpressure_enable_bit,
    output logic port0_tx_flowctl_enable_bit,
    output logic port0_rx_flowctl_enable_bit,
    output logic defaultsReady_q
);

    strap_t strap_q;
    load_state_t state_q;
    load_state_t state_d;
    logic [2:0] manualFc_q;
    logic [1:0] advPause_q;
    logic [5:0] partner_q;
    logic pinMeta_q;
    logic pinSync_q;
    logic isMac;
    logic pinMeansFull;
    logic [5:0] partnerDefault;
    logic [2:0] manualFcDefault;
    logic [1:0] advDefault;
    logic wrMfc;
    logic wrAdv;
    logic [31:0] readMux;
    logic [31:0] statusWord;

    // The shared strap bit feeds both the ability bits and the pin polarity.
    // Full duplex strap sets the FD bits and clears the HD bits.
    assign partnerDefault = {                                     // [RULE1]
        {2{strap_q.port0_fullduplex_flowctl_strap}},              // [RULE8]
        strap_q.duplexStrap, ~strap_q.duplexStrap,
        strap_q.duplexStrap, ~strap_q.duplexStrap};
    assign manualFcDefault = {                                    // [RULE6]
        strap_q.port0_backpressure_strap,
        {2{strap_q.port0_fullduplex_flowctl_strap}}};             // [RULE7]
    assign advDefault = {2{strap_q.port0_manual_flowctl_strap}};  // [RULE9]

    assign isMac = (port0Mode == `MODE_MII_MAC)                   // [RULE4]
        || (port0Mode == `MODE_RMII_MAC);
    assign pinMeansFull = (pinSync_q == strap_q.duplexStrap);     // [RULE2] [RULE3]

    assign wrMfc = regReq.wr && (regReq.addr == `OFS_MANUAL_FC);
    assign wrAdv = regReq.wr && (regReq.addr == `OFS_VPHY_ADV);

    assign statusWord = {29'h0000000, (state_q == S_RUN), isMac,
        fullDuplex_q};
    assign readMux =
        (regReq.addr == `OFS_STRAP) ? {28'h0000000, strap_q} :
        (regReq.addr == `OFS_MANUAL_FC) ? {29'h0000000, manualFc_q} :
        (regReq.addr == `OFS_VPHY_ADV) ?
            (32'(advPause_q) << `ADV_PAUSE_LSB) :
        (regReq.addr == `OFS_VPHY_PARTNER) ?
            ((32'(partner_q[5:4]) << `LP_PAUSE_LSB)
             | (32'(partner_q[3:0]) << `LP_ABIL_LSB)) :
        (regReq.addr == `OFS_STATUS) ? statusWord : 32'h00000000;

    assign port0_backpressure_enable_bit = manualFc_q[`MFC_BP_BIT];
    assign port0_tx_flowctl_enable_bit = manualFc_q[`MFC_TX_BIT];
    assign port0_rx_flowctl_enable_bit = manualFc_q[`MFC_RX_BIT];

    // An EEPROM load in any state re-runs the copy so targets never go stale.
    always_comb
    begin
        case (state_q)
            S_INIT: state_d = S_APPLY;
            S_APPLY: state_d = eeLoad.valid ? S_APPLY : S_RUN;
            S_RUN: state_d = eeLoad.valid ? S_APPLY : S_RUN;
            default: state_d = S_INIT;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_q <= S_INIT;
            strap_q <= `STRAP_RST;                                // [RULE5]
        end
        else
        begin
            state_q <= state_d;
            if (eeLoad.valid)
                strap_q <= eeLoad.straps;                         // [RULE10]
        end
    end

    // Copy wins over a software write in the same cycle; software sees the
    // defaults only after the ready flag rises.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            manualFc_q <= 3'h0;
            advPause_q <= 2'h0;
            partner_q <= 6'h00;
        end
        else if (state_q == S_APPLY)
        begin
            manualFc_q <= manualFcDefault;                        // [RULE11]
            advPause_q <= advDefault;
            partner_q <= partnerDefault;
        end
        else
        begin
            if (wrMfc)
                manualFc_q <= regReq.wdata[`MFC_BP_BIT:`MFC_RX_BIT];
            if (wrAdv)
                advPause_q <=
                    regReq.wdata[`ADV_PAUSE_LSB + 1:`ADV_PAUSE_LSB];
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pinMeta_q <= 1'b0;
            pinSync_q <= 1'b0;
            fullDuplex_q <= 1'b0;
            defaultsReady_q <= 1'b0;
            rdata_q <= 32'h00000000;
        end
        else
        begin
            pinMeta_q <= port0_dup_indicator_pin;
            pinSync_q <= pinMeta_q;
            fullDuplex_q <= isMac && pinMeansFull;                // [RULE4]
            defaultsReady_q <= (state_d == S_RUN);                // [RULE11]
            rdata_q <= regReq.rd ? readMux : 32'h00000000;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence seqApply;
        state_q == S_APPLY;
    endsequence

    sequence seqLoad;
        eeLoad.valid;
    endsequence

    AST_LP_DUPLEX: assert property ( // [RULE1]
        seqApply |=> partner_q[3:0] == {$past(strap_q.duplexStrap),
            ~$past(strap_q.duplexStrap), $past(strap_q.duplexStrap),
            ~$past(strap_q.duplexStrap)})
        else $error("Partner duplex bits differ from the duplex strap.");

    AST_SHARED_BIT: assert property ( // [RULE2]
        (isMac && $stable(pinSync_q) && $stable(strap_q))
            |=> fullDuplex_q
                == ($past(pinSync_q) == $past(strap_q.duplexStrap)))
        else $error("Pin polarity does not follow the shared strap bit.");

    AST_POL_LOW: assert property ( // [RULE3]
        (isMac && !strap_q.duplexStrap && !pinSync_q) |=> fullDuplex_q)
        else $error("Low pin with polarity 0 was not full duplex.");

    AST_NON_MAC: assert property ( // [RULE4]
        !isMac |=> !fullDuplex_q)
        else $error("Full duplex reported outside a MAC mode.");

    AST_RESET_POL: assert property ( // [RULE5]
        ($fell(rst) && !$past(eeLoad.valid)) |-> strap_q == `STRAP_RST)
        else $error("Strap bits left reset with the wrong defaults.");

    AST_BP_DEFAULT: assert property ( // [RULE6]
        seqApply |=> manualFc_q[`MFC_BP_BIT]
            == $past(strap_q.port0_backpressure_strap))
        else $error("Backpressure enable not copied from its strap.");

    AST_FC_DEFAULT: assert property ( // [RULE7]
        seqApply |=> manualFc_q[1:0]
            == {2{$past(strap_q.port0_fullduplex_flowctl_strap)}})
        else $error("Flow control enables not copied from their strap.");

    AST_LP_PAUSE: assert property ( // [RULE8]
        seqApply |=> partner_q[5:4]
            == {2{$past(strap_q.port0_fullduplex_flowctl_strap)}})
        else $error("Partner pause bits not copied from their strap.");

    AST_ADV_PAUSE: assert property ( // [RULE9]
        seqApply |=> advPause_q
            == {2{$past(strap_q.port0_manual_flowctl_strap)}})
        else $error("Advertised pause bits not copied from their strap.");

    AST_EE_OVERRIDE: assert property ( // [RULE10]
        seqLoad |=> ((strap_q == $past(eeLoad.straps)) and seqApply))
        else $error("EEPROM values did not replace the straps.");

    AST_READY_AFTER_COPY: assert property ( // [RULE11]
        ($fell(rst) ##0 (!eeLoad.valid) [*2]) |-> ##[0:1] defaultsReady_q)
        else $error("Defaults not ready within two cycles of reset.");

endmodule

// ### design/port0_strap_pkg.sv
package port0_strap_pkg;

    typedef struct packed {
        logic port0_manual_flowctl_strap;
        logic port0_fullduplex_flowctl_strap;
        logic port0_backpressure_strap;
        logic duplexStrap;
    } strap_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef struct packed {
        logic valid;
        strap_t straps;
    } ee_load_t;

    typedef enum logic [1:0] {
        S_INIT = 2'b00,
        S_APPLY = 2'b01,
        S_RUN = 2'b10
    } load_state_t;

endpackage

// ### design/strap_params.svh
`ifndef PORT0_STRAP_PARAMS_SVH
`define PORT0_STRAP_PARAMS_SVH
// Behaviour
// (RULE1) The duplex select strap sets the default of the four partner duplex ability bits and resets to 1.
// (RULE2) Duplex select and duplex pin polarity share one strap bit, so one value sets both.
// (RULE3) Polarity 0 means a low duplex pin is full duplex, polarity 1 means a high pin is full duplex.
// (RULE4) The pin polarity only applies while port 0 is in MII MAC or RMII MAC mode.
// (RULE5) The duplex pin polarity strap resets to 1, so a high pin means full duplex.
// (RULE6) The backpressure strap, default 1, gives the default of the backpressure enable bit.
// (RULE7) The full-duplex flow control strap, default 1, gives the default of both transmit and receive flow control enables.
// (RULE8) The same strap also gives the default of the partner asymmetric pause and pause bits.
// (RULE9) The manual flow control strap, default 0, gives the default of the advertised asymmetric and symmetric pause bits.
// (RULE10) Soft-strap values can be replaced by values from the EEPROM loader.
// (RULE11) Strap values are copied into the target bits after reset before they are read as valid.

`define ADDR_W 8
`define DATA_W 32

`define OFS_STRAP 8'h00
`define OFS_MANUAL_FC 8'h04
`define OFS_VPHY_ADV 8'h08
`define OFS_VPHY_PARTNER 8'h0c
`define OFS_STATUS 8'h10

// Strap reset value {manual, fullduplex fc, backpressure, duplex}.
`define STRAP_RST 4'h7

`define MFC_RX_BIT 0
`define MFC_TX_BIT 1
`define MFC_BP_BIT 2

`define ADV_PAUSE_LSB 10
`define LP_ABIL_LSB 5
`define LP_PAUSE_LSB 10

`define STS_FULLDUP_BIT 0
`define STS_MAC_BIT 1
`define STS_READY_BIT 2

`define MODE_MII_MAC 2'h1
`define MODE_RMII_MAC 2'h2
`endif

// ### tb/tb.sv
`timescale 1ns/1ps
`include "strap_params.svh"

module tb;
    import port0_strap_pkg::*;
    logic clk = 0;
    logic rst = 1;
    reg_req_t regReq = '0;
    ee_load_t eeLoad = '0;
    logic [1:0] port0Mode = 2'h1;
    logic dupPin = 1'b1;
    logic [31:0] rdata_q;
    logic fullDuplex_q, bp, tx, rx, defaultsReady_q;
    logic rdSeen = 0;
    logic [31:0] expQ[$];
    int mismatches = 0;
    int checked = 0;

    port0_strap_defaults DUT (.clk(clk), .rst(rst), .regReq(regReq),
        .rdata_q(rdata_q), .eeLoad(eeLoad), .port0Mode(port0Mode),
        .port0_dup_indicator_pin(dupPin), .fullDuplex_q(fullDuplex_q),
        .port0_backpressure_enable_bit(bp), .port0_tx_flowctl_enable_bit(tx),
        .port0_rx_flowctl_enable_bit(rx), .defaultsReady_q(defaultsReady_q));

    initial forever #5 clk = ~clk;

    task automatic end_sim();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Read data is only valid in the cycle after the strobe, so sample mid-cycle.
    always @(posedge clk) rdSeen <= regReq.rd;
    always @(negedge clk)
    begin
        if (rdSeen)
            chk(rdata_q, expQ.pop_front());
        else
            chk(rdata_q, 32'h0);
    end

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        regReq <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        expQ.push_back(e);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk) regReq <= '0;
    endtask

    task automatic waitReady();
        repeat (20) if (defaultsReady_q !== 1'b1) @(negedge clk);
        chk({31'h0, defaultsReady_q}, 32'h1);
    endtask

    function automatic logic [31:0] mfc(input logic [3:0] s);
        return {29'h0, s[1], s[2], s[2]};
    endfunction

    function automatic logic [31:0] lp(input logic [3:0] s);
        return {20'h0, s[2], s[2], 1'b0, s[0], ~s[0], s[0], ~s[0], 5'h0};
    endfunction

    function automatic logic [31:0] sts(input logic [3:0] s,
        input logic [1:0] m, input logic p);
        logic mac;
        mac = (m == 2'h1) || (m == 2'h2);
        return {29'h0, 1'b1, mac, mac && (p == s[0])};
    endfunction

    task automatic checkAll(input logic [3:0] s);
        rd(`OFS_STRAP, {28'h0, s});
        rd(`OFS_MANUAL_FC, mfc(s));
        rd(`OFS_VPHY_ADV, {20'h0, s[3], s[3], 10'h0});
        rd(`OFS_VPHY_PARTNER, lp(s));
        idle(1);
        chk({29'h0, bp, tx, rx}, mfc(s));
    endtask

    initial
    begin
        logic [3:0] s;
        logic [3:0] r;
        logic [31:0] w;
        void'($urandom(46121));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        waitReady();
        checkAll(4'h7);
        rd(`OFS_STATUS, 32'h7);
        rd(8'h20, 32'h0);
        wr(`OFS_STRAP, 32'h0);
        rd(`OFS_STRAP, 32'h7);
        idle(1);
        $display("test reset_defaults done");
        r = 4'($urandom);
        for (int i = 0; i < 16; i++)
        begin
            s = 4'(i) ^ r;
            w = $urandom;
            wr(`OFS_MANUAL_FC, w);
            wr(`OFS_VPHY_ADV, w);
            rd(`OFS_MANUAL_FC, w & 32'h7);
            rd(`OFS_VPHY_ADV, w & 32'hc00);
            // The load must overwrite what software just wrote.
            @(posedge clk);
            regReq <= '0;
            eeLoad <= {1'b1, s};
            @(posedge clk);
            eeLoad <= '0;
            idle(2);
            waitReady();
            checkAll(s);
            for (int m = 0; m < 8; m++)
            begin
                port0Mode <= 2'(m >> 1);
                dupPin <= 1'(m);
                idle(4);
                chk({31'h0, fullDuplex_q}, sts(s, 2'(m >> 1), 1'(m)) & 32'h1);
                rd(`OFS_STATUS, sts(s, 2'(m >> 1), 1'(m)));
                idle(1);
            end
        end
        $display("test strap_loads done");
        end_sim();
    end

    initial
    begin
        #100000;
        mismatches++;
        end_sim();
    end
endmodule
